// File: rtl/clt_pkg.sv
// Purpose: Shared constants and types for the configurable logic tile
// Assumes: One 20 MHz clock, synchronous active-high reset
// Notes:   Bus map and control-word layout are local choices
package clt_pkg;
    localparam int DATA_W    = 8;
    localparam int CFG_W     = 16;
    localparam int CFG_DEPTH = 8;
    localparam int CFG_AW    = 3;
    localparam int SOP_IN    = 12;
    localparam int SOP_PT    = 8;
    localparam int SOP_OUT   = 4;
    localparam int SOP_NUM   = 2;
    localparam int Q_DEPTH   = 4;
    localparam int Q_CW      = 3;
    localparam int Q_PW      = 2;
    localparam int BUS_AW    = 4;
    localparam int CLK_PERIOD_NS = 50;
    // System bus word addresses
    localparam logic [3:0] ADDR_ACC0  = 4'h0;
    localparam logic [3:0] ADDR_ACC1  = 4'h1;
    localparam logic [3:0] ADDR_DATA0 = 4'h2;
    localparam logic [3:0] ADDR_DATA1 = 4'h3;
    localparam logic [3:0] ADDR_Q0    = 4'h4;
    localparam logic [3:0] ADDR_Q1    = 4'h5;
    localparam int ADDR_CFG_BIT = 3;
    // Control-word field positions
    localparam int CF_FUNC  = 0;
    localparam int CF_SRCA  = 3;
    localparam int CF_SRCB  = 4;
    localparam int CF_WR_A0 = 6;
    localparam int CF_WR_A1 = 7;
    localparam int CF_LD_A0 = 8;
    localparam int CF_LD_A1 = 9;
    localparam int CF_PUSH0 = 10;
    localparam int CF_PUSH1 = 11;
    localparam int CF_CHAIN = 12;
    localparam logic [7:0]  REG_RESET = 8'h00;
    localparam logic [15:0] CFG_RESET = 16'h0000;
    localparam logic [2:0]  Q_CNT_FULL = 3'h4;
    typedef enum logic [2:0] {
        ALU_INC, ALU_DEC, ALU_ADD, ALU_SUB,
        ALU_AND, ALU_OR, ALU_XOR, ALU_PASS
    } clt_alu_op_t;
endpackage : clt_pkg

// File: rtl/clt_cfg_ram.sv
// Purpose: Control store, eight 16-bit words, registered read
// Assumes: Write from system bus, read address from routing
// Notes:   Read data appears one cycle after the address
`timescale 1ns/1ps
`default_nettype none
module clt_cfg_ram
    import clt_pkg::*;
(
    input  wire logic                    ref_clk,
    input  wire logic                    reset,
    input  wire logic                    wrEn,
    input  wire logic [clt_pkg::CFG_AW-1:0] wrAddr,
    input  wire logic [clt_pkg::CFG_W-1:0]  wrData,
    input  wire logic [clt_pkg::CFG_AW-1:0] rdAddr,
    output var  logic [clt_pkg::CFG_W-1:0]  rdData
);
    logic [CFG_W-1:0] mem_reg [CFG_DEPTH];

    // Storage cleared by reset: an unloaded word would push unknowns
    // into the queues, so the extra reset fan-out is worth paying for
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            for (int w = 0; w < CFG_DEPTH; w++) begin
                mem_reg[w] <= CFG_RESET;
            end
        end else if (wrEn) begin
            mem_reg[wrAddr] <= wrData;
        end
    end

    // Registered read port
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            rdData <= CFG_RESET;
        end else begin
            rdData <= mem_reg[rdAddr];
        end
    end
endmodule : clt_cfg_ram
`default_nettype wire

// File: rtl/clt_sop_array.sv
// Purpose: One 12-input, 8-term, 4-output sum-of-products array
// Assumes: Configuration held static by the tile's owner
// Notes:   A term with no input enabled reads as zero
`timescale 1ns/1ps
`default_nettype none
module clt_sop_array
    import clt_pkg::*;
(
    input  wire logic                        ref_clk,
    input  wire logic                        reset,
    input  wire logic [clt_pkg::SOP_IN-1:0]  sopIn,
    input  wire logic [clt_pkg::SOP_PT*clt_pkg::SOP_IN-1:0] trueSel,
    input  wire logic [clt_pkg::SOP_PT*clt_pkg::SOP_IN-1:0] compSel,
    input  wire logic [clt_pkg::SOP_OUT*clt_pkg::SOP_PT-1:0] orSel,
    input  wire logic [clt_pkg::SOP_OUT-1:0] regSel,
    output var  logic [clt_pkg::SOP_OUT-1:0] sopOut
);
    logic [SOP_PT-1:0]  term;
    logic [SOP_OUT-1:0] sumComb;
    logic [SOP_OUT-1:0] sum_reg;

    // Every input reaches every term, either polarity
    for (genvar t = 0; t < SOP_PT; t++) begin : g_term
        logic [SOP_IN-1:0] tSel;
        logic [SOP_IN-1:0] cSel;
        assign tSel = trueSel[t*SOP_IN +: SOP_IN];
        assign cSel = compSel[t*SOP_IN +: SOP_IN];
        assign term[t] = (|(tSel | cSel))
                       & (&(~tSel | sopIn))
                       & (&(~cSel | ~sopIn));
    end

    // Same eight-wide OR for every output
    for (genvar o = 0; o < SOP_OUT; o++) begin : g_sum
        assign sumComb[o] = |(term & orSel[o*SOP_PT +: SOP_PT]);
        assign sopOut[o] = regSel[o] ? sum_reg[o] : sumComb[o];
    end

    // State bits for the registered outputs
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            sum_reg <= '0;
        end else begin
            sum_reg <= sumComb;
        end
    end

    property p_reg_out;
        @(posedge ref_clk) disable iff (reset)
        !$past(reset) && $stable(regSel)
        |-> (sopOut & regSel) == ($past(sumComb) & regSel);
    endproperty
    a_reg_out: assert property (p_reg_out)
        else $error("registered output lost its state");

    property p_empty_term;
        @(posedge ref_clk) disable iff (reset)
        (trueSel[SOP_IN-1:0] | compSel[SOP_IN-1:0]) == '0 |-> !term[0];
    endproperty
    a_empty_term: assert property (p_empty_term)
        else $error("empty product term is active");
endmodule : clt_sop_array
`default_nettype wire

// File: rtl/clt_tile.sv
// Purpose: Configurable logic tile, two arrays plus 8-bit datapath
// Assumes: Bus master and routing logic share ref_clk
// Notes:   Array outputs in combinational mode are not flopped
`timescale 1ns/1ps
`default_nettype none
module clt_tile
    import clt_pkg::*;
(
    input  wire logic                    ref_clk,
    input  wire logic                    reset,
    input  wire logic [clt_pkg::SOP_NUM*clt_pkg::SOP_IN-1:0] sopIn,
    input  wire logic [clt_pkg::SOP_NUM*clt_pkg::SOP_PT*clt_pkg::SOP_IN-1:0] sopTrueSel,
    input  wire logic [clt_pkg::SOP_NUM*clt_pkg::SOP_PT*clt_pkg::SOP_IN-1:0] sopCompSel,
    input  wire logic [clt_pkg::SOP_NUM*clt_pkg::SOP_OUT*clt_pkg::SOP_PT-1:0] sopOrSel,
    input  wire logic [clt_pkg::SOP_NUM*clt_pkg::SOP_OUT-1:0] sopRegSel,
    output var  logic [clt_pkg::SOP_NUM*clt_pkg::SOP_OUT-1:0] sopOut,
    input  wire logic [clt_pkg::CFG_AW-1:0]  cfgAddr,
    input  wire logic [1:0]              qDirOut,
    input  wire logic                    busWrite,
    input  wire logic                    busRead,
    input  wire logic [clt_pkg::BUS_AW-1:0]  busAddr,
    input  wire logic [clt_pkg::CFG_W-1:0]   busWdata,
    output var  logic [clt_pkg::DATA_W-1:0]  busRdata,
    input  wire logic                    chainCarryIn,
    input  wire logic                    chainZeroIn,
    output var  logic                    chainCarryOut,
    output var  logic                    chainZeroOut,
    output var  logic [1:0]              cmpOut,
    output var  logic [1:0]              zeroOut,
    output var  logic [1:0]              onesOut,
    output var  logic                    ovfOut,
    output var  logic [1:0]              qEmpty,
    output var  logic [1:0]              qFull
);
    logic [DATA_W-1:0] acc0_reg, acc1_reg, data0_reg, data1_reg;
    logic [DATA_W-1:0] acc0_next, acc1_next;
    logic [CFG_W-1:0]  cfgWord;
    clt_alu_op_t       aluOp;
    logic [DATA_W-1:0] opA, opB, aluResult;
    logic [DATA_W:0]   sum9;
    logic              carryIn, aluOvf;
    logic [1:0]        busWrQ, busRdQ, qPush, qPop, ldAcc;
    logic [DATA_W-1:0] qPushData [2];
    logic [DATA_W-1:0] qHead [2];
    logic [Q_CW-1:0]   qCount [2];

    // Bus word decode, shared by reads and writes
    function automatic logic hit(input logic [BUS_AW-1:0] a,
                                 input logic [BUS_AW-1:0] target);
        return a == target;
    endfunction : hit

    // Two independent arrays on the routing inputs
    for (genvar k = 0; k < SOP_NUM; k++) begin : g_sop
        clt_sop_array u_sop (
            .ref_clk (ref_clk),
            .reset   (reset),
            .sopIn   (sopIn[k*SOP_IN +: SOP_IN]),
            .trueSel (sopTrueSel[k*SOP_PT*SOP_IN +: SOP_PT*SOP_IN]),
            .compSel (sopCompSel[k*SOP_PT*SOP_IN +: SOP_PT*SOP_IN]),
            .orSel   (sopOrSel[k*SOP_OUT*SOP_PT +: SOP_OUT*SOP_PT]),
            .regSel  (sopRegSel[k*SOP_OUT +: SOP_OUT]),
            .sopOut  (sopOut[k*SOP_OUT +: SOP_OUT])
        );
    end

    // Control store, address straight from routing
    clt_cfg_ram u_cfg (
        .ref_clk (ref_clk),
        .reset   (reset),
        .wrEn    (busWrite && busAddr[ADDR_CFG_BIT]),
        .wrAddr  (busAddr[CFG_AW-1:0]),
        .wrData  (busWdata),
        .rdAddr  (cfgAddr),
        .rdData  (cfgWord)
    );

    // Operand selection and single-cycle ALU
    always_comb begin
        aluOp   = clt_alu_op_t'(cfgWord[CF_FUNC +: 3]);
        opA     = cfgWord[CF_SRCA] ? acc1_reg : acc0_reg;
        case (cfgWord[CF_SRCB +: 2])
            2'h0:    opB = data0_reg;
            2'h1:    opB = data1_reg;
            2'h2:    opB = acc0_reg;
            default: opB = acc1_reg;
        endcase
        carryIn = cfgWord[CF_CHAIN] & chainCarryIn;
        sum9    = '0;
        aluOvf  = 1'b0;
        case (aluOp)
            ALU_INC: sum9 = {1'b0, opA} + 9'h001;
            ALU_DEC: sum9 = {1'b0, opA} - 9'h001;
            ALU_ADD: begin
                sum9   = {1'b0, opA} + {1'b0, opB} + {8'h00, carryIn};
                aluOvf = (opA[7] == opB[7]) && (sum9[7] != opA[7]);
            end
            ALU_SUB: begin
                sum9   = {1'b0, opA} - {1'b0, opB} - {8'h00, carryIn};
                aluOvf = (opA[7] != opB[7]) && (sum9[7] != opA[7]);
            end
            ALU_AND: sum9 = {1'b0, opA & opB};
            ALU_OR:  sum9 = {1'b0, opA | opB};
            ALU_XOR: sum9 = {1'b0, opA ^ opB};
            default: sum9 = {1'b0, opA};
        endcase
        aluResult = sum9[DATA_W-1:0];
    end

    // Queue request steering; direction set per queue
    for (genvar i = 0; i < 2; i++) begin : g_qreq
        assign busWrQ[i] = busWrite && hit(busAddr, ADDR_Q0 + 4'(i));
        assign busRdQ[i] = busRead && hit(busAddr, ADDR_Q0 + 4'(i));
        assign ldAcc[i]  = cfgWord[CF_LD_A0 + i] && !qEmpty[i];
        assign qPush[i]  = !qFull[i] && (qDirOut[i] ?
                           cfgWord[CF_PUSH0 + i] : busWrQ[i]);
        assign qPop[i]   = !qEmpty[i] && (qDirOut[i] ? busRdQ[i] : ldAcc[i]);
        assign qPushData[i] = qDirOut[i] ? aluResult : busWdata[DATA_W-1:0];
    end

    // Four-byte queues; full refuses push, empty refuses pop
    for (genvar i = 0; i < 2; i++) begin : g_queue
        logic [DATA_W-1:0] mem_reg [Q_DEPTH];
        logic [Q_PW-1:0]   wrPtr_reg, rdPtr_reg;
        logic [Q_CW-1:0]   cnt_reg, cnt_next;
        assign cnt_next = cnt_reg + Q_CW'(qPush[i]) - Q_CW'(qPop[i]);
        assign qHead[i]  = mem_reg[rdPtr_reg];
        assign qCount[i] = cnt_reg;
        always_ff @(posedge ref_clk) begin
            if (qPush[i]) begin
                mem_reg[wrPtr_reg] <= qPushData[i];
            end
        end
        always_ff @(posedge ref_clk) begin
            if (reset) begin
                wrPtr_reg <= '0;
                rdPtr_reg <= '0;
                cnt_reg   <= '0;
                qEmpty[i] <= 1'b1;
                qFull[i]  <= 1'b0;
            end else begin
                wrPtr_reg <= wrPtr_reg + Q_PW'(qPush[i]);
                rdPtr_reg <= rdPtr_reg + Q_PW'(qPop[i]);
                cnt_reg   <= cnt_next;
                qEmpty[i] <= cnt_next == '0;
                qFull[i]  <= cnt_next == Q_CNT_FULL;
            end
        end
    end

    // Accumulator next values: bus write, then queue load, then ALU
    always_comb begin
        acc0_next = acc0_reg;
        acc1_next = acc1_reg;
        if (busWrite && hit(busAddr, ADDR_ACC0)) begin
            acc0_next = busWdata[DATA_W-1:0];
        end else if (ldAcc[0] && !qDirOut[0]) begin
            acc0_next = qHead[0];
        end else if (cfgWord[CF_WR_A0]) begin
            acc0_next = aluResult;
        end
        if (busWrite && hit(busAddr, ADDR_ACC1)) begin
            acc1_next = busWdata[DATA_W-1:0];
        end else if (ldAcc[1] && !qDirOut[1]) begin
            acc1_next = qHead[1];
        end else if (cfgWord[CF_WR_A1]) begin
            acc1_next = aluResult;
        end
    end

    // Working registers
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            acc0_reg  <= REG_RESET;
            acc1_reg  <= REG_RESET;
            data0_reg <= REG_RESET;
            data1_reg <= REG_RESET;
        end else begin
            acc0_reg <= acc0_next;
            acc1_reg <= acc1_next;
            if (busWrite && hit(busAddr, ADDR_DATA0)) begin
                data0_reg <= busWdata[DATA_W-1:0];
            end
            if (busWrite && hit(busAddr, ADDR_DATA1)) begin
                data1_reg <= busWdata[DATA_W-1:0];
            end
        end
    end

    // Bus read data, one cycle after the request; unmapped reads zero
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            busRdata <= REG_RESET;
        end else if (busRead) begin
            case (busAddr)
                ADDR_ACC0:  busRdata <= acc0_reg;
                ADDR_ACC1:  busRdata <= acc1_reg;
                ADDR_DATA0: busRdata <= data0_reg;
                ADDR_DATA1: busRdata <= data1_reg;
                ADDR_Q0:    busRdata <= qPop[0] ? qHead[0] : REG_RESET;
                ADDR_Q1:    busRdata <= qPop[1] ? qHead[1] : REG_RESET;
                default:    busRdata <= REG_RESET;
            endcase
        end
    end

    // Conditions, flopped so neighbours see clean levels
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            cmpOut        <= '0;
            zeroOut       <= '0;
            onesOut       <= '0;
            ovfOut        <= 1'b0;
            chainCarryOut <= 1'b0;
            chainZeroOut  <= 1'b0;
        end else begin
            cmpOut[0]     <= acc0_reg == data0_reg;
            cmpOut[1]     <= acc1_reg < data1_reg;
            zeroOut[0]    <= acc0_reg == '0;
            zeroOut[1]    <= acc1_reg == '0;
            onesOut[0]    <= &acc0_reg;
            onesOut[1]    <= &acc1_reg;
            ovfOut        <= aluOvf;
            chainCarryOut <= sum9[DATA_W];
            chainZeroOut  <= (acc0_reg == '0) && chainZeroIn;
        end
    end

    // Checks: an add of A0 and D0 into A0 when nothing else writes it
    sequence s_add_a0;
        cfgWord[CF_FUNC +: 3] == 3'(ALU_ADD) && cfgWord[CF_WR_A0]
        && !cfgWord[CF_SRCA] && cfgWord[CF_SRCB +: 2] == 2'h0
        && !carryIn && !ldAcc[0] && !(busWrite && busAddr == ADDR_ACC0);
    endsequence
    property p_add;
        @(posedge ref_clk) disable iff (reset)
        s_add_a0 |=> acc0_reg == 8'($past(acc0_reg) + $past(data0_reg));
    endproperty
    a_add: assert property (p_add)
        else $error("add result wrong");

    property p_inc;
        @(posedge ref_clk) disable iff (reset)
        cfgWord[CF_FUNC +: 3] == 3'(ALU_INC) && cfgWord[CF_SRCA]
        && cfgWord[CF_WR_A1] && !ldAcc[1] && !(busWrite && busAddr == ADDR_ACC1)
        |=> acc1_reg == 8'($past(acc1_reg) + 8'h01);
    endproperty
    a_inc: assert property (p_inc)
        else $error("increment not done in one cycle");

    sequence s_cfg_load;
        busWrite && busAddr[ADDR_CFG_BIT]
        ##1 cfgAddr == $past(busAddr[CFG_AW-1:0]);
    endsequence
    property p_cfg;
        @(posedge ref_clk) disable iff (reset)
        s_cfg_load |=> cfgWord == $past(busWdata, 2);
    endproperty
    a_cfg: assert property (p_cfg)
        else $error("control word not selected");

    property p_cmp;
        @(posedge ref_clk) disable iff (reset)
        acc1_reg < data1_reg |=> cmpOut[1] && !(zeroOut[1] && onesOut[1]);
    endproperty
    a_cmp: assert property (p_cmp)
        else $error("compare flag wrong");

    property p_zero;
        @(posedge ref_clk) disable iff (reset)
        acc0_reg == '0 |=> zeroOut[0] && !onesOut[0];
    endproperty
    a_zero: assert property (p_zero)
        else $error("zero detect wrong");

    property p_rd;
        @(posedge ref_clk) disable iff (reset)
        busRead && busAddr == ADDR_DATA1 |=> busRdata == $past(data1_reg);
    endproperty
    a_rd: assert property (p_rd)
        else $error("bus read data wrong");

    property p_wr;
        @(posedge ref_clk) disable iff (reset)
        busWrite && busAddr == ADDR_DATA0 |=> data0_reg == $past(busWdata[7:0]);
    endproperty
    a_wr: assert property (p_wr)
        else $error("bus write lost");

    property p_depth;
        @(posedge ref_clk) disable iff (reset)
        qCount[0] <= Q_CNT_FULL && (qFull[0] == (qCount[0] == Q_CNT_FULL));
    endproperty
    a_depth: assert property (p_depth)
        else $error("queue depth exceeded");

    property p_full_refuse;
        @(posedge ref_clk) disable iff (reset)
        qFull[0] && !qPop[0] |=> qCount[0] == Q_CNT_FULL;
    endproperty
    a_full_refuse: assert property (p_full_refuse)
        else $error("full queue accepted data");

    property p_chain;
        @(posedge ref_clk) disable iff (reset)
        cfgWord[CF_FUNC +: 3] == 3'(ALU_ADD) && (&opA) && opB != '0
        |=> chainCarryOut;
    endproperty
    a_chain: assert property (p_chain)
        else $error("carry not chained out");
endmodule : clt_tile
`default_nettype wire

// File: verif/clt_bus_model.sv
// Purpose: System bus master model facing the logic tile
// Assumes: One-cycle strobes, read data valid after taking edge
// Notes:   Released lines show inverted last value, never stale
`timescale 1ns/1ps
`default_nettype none
module clt_bus_model
    import clt_pkg::*;
(
    input  wire logic                       ref_clk,
    input  wire logic [clt_pkg::DATA_W-1:0] busRdata,
    output var  logic                       busWrite,
    output var  logic                       busRead,
    output var  logic [clt_pkg::BUS_AW-1:0] busAddr,
    output var  logic [clt_pkg::CFG_W-1:0]  busWdata
);
    // Idle bus at time zero
    initial begin
        busWrite = 1'b0;
        busRead  = 1'b0;
        busAddr  = 4'h0;
        busWdata = 16'h0000;
    end

    // One write, held over its taking edge
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        busWrite <= 1'b1;
        busAddr  <= a;
        busWdata <= d;
        @(posedge ref_clk);
        busWrite <= 1'b0;
        busAddr  <= ~a;
        busWdata <= ~d; // Released data must not look valid
    endtask : wr

    // One read; data taken just after the taking edge
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        busRead <= 1'b1;
        busAddr <= a;
        @(posedge ref_clk);
        busRead <= 1'b0;
        busAddr <= ~a;
        #1 d = busRdata;
    endtask : rd
endmodule : clt_bus_model
`default_nettype wire

// File: verif/tb_top.sv
// Purpose: Self-checking bench for the configurable logic tile
// Assumes: Bus model on the system side, bench drives routing side
// Notes:   Idle control word 7 does no writes, so values stay put
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import clt_pkg::*;
    logic         ref_clk, reset, chainCarryIn, chainZeroIn;
    logic         busWrite, busRead, chainCarryOut, chainZeroOut, ovfOut;
    logic [23:0]  sopIn;
    logic [191:0] trueSel, compSel;
    logic [63:0]  orSel;
    logic [7:0]   regSel, sopOut, busRdata, v;
    logic [2:0]   cfgAddr;
    logic [3:0]   busAddr;
    logic [15:0]  busWdata;
    logic [1:0]   qDirOut, cmpOut, zeroOut, onesOut, qEmpty, qFull;
    int           mismatches, check_count, cycles;
    localparam logic [15:0] CW_TABLE [8] = '{16'h0040, 16'h0100,
        16'h0825, 16'h0088, 16'h0002, 16'h0003, 16'h1042, 16'h0000};

    clt_tile i_clt_tile (.ref_clk(ref_clk), .reset(reset), .sopIn(sopIn),
        .sopTrueSel(trueSel), .sopCompSel(compSel), .sopOrSel(orSel),
        .sopRegSel(regSel), .sopOut(sopOut), .cfgAddr(cfgAddr),
        .qDirOut(qDirOut), .busWrite(busWrite), .busRead(busRead),
        .busAddr(busAddr), .busWdata(busWdata), .busRdata(busRdata),
        .chainCarryIn(chainCarryIn), .chainZeroIn(chainZeroIn),
        .chainCarryOut(chainCarryOut), .chainZeroOut(chainZeroOut),
        .cmpOut(cmpOut), .zeroOut(zeroOut), .onesOut(onesOut),
        .ovfOut(ovfOut), .qEmpty(qEmpty), .qFull(qFull));
    clt_bus_model i_clt_bus_model (.ref_clk(ref_clk), .busRdata(busRdata),
        .busWrite(busWrite), .busRead(busRead), .busAddr(busAddr),
        .busWdata(busWdata));

    // Clock at 20 MHz
    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic results;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : results

    // Hang guard, well above the few hundred cycles needed
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            results();
        end
    end

    function automatic logic [7:0] alu(input int f, input logic [7:0] a, b);
        case (f)
            0: alu = a + 8'h01;
            1: alu = a - 8'h01;
            2: alu = a + b;
            3: alu = a - b;
            4: alu = a & b;
            5: alu = a | b;
            6: alu = a ^ b;
            default: alu = a;
        endcase
    endfunction : alu

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        i_clt_bus_model.wr(a, d);
    endtask : wr

    task automatic rchk(input logic [3:0] a, input logic [7:0] e);
        i_clt_bus_model.rd(a, v);
        chk({8'h00, v}, {8'h00, e});
    endtask : rchk

    // One cycle on a control word, then back to idle word 7
    task automatic run(input logic [2:0] k);
        @(posedge ref_clk);
        cfgAddr <= k;
        @(posedge ref_clk);
        cfgAddr <= 3'h7;
        repeat (3) @(posedge ref_clk);
    endtask : run

    task automatic t_reset;
        @(posedge ref_clk);
        #1;
        chk(qEmpty, 2'b11);
        chk(qFull, 2'b00);
        chk(busRdata, 8'h00);
        chk(zeroOut, 2'b11);
        chk(cmpOut, 2'b01);
        chk(onesOut, 2'b00);
        $display("test reset done");
    endtask : t_reset

    task automatic t_regs;
        for (int i = 0; i < 8; i++) wr(4'(8 + i), CW_TABLE[i]);
        for (int i = 0; i < 4; i++) wr(4'(i), {8'hEE, 8'(8'h5A + i)});
        for (int i = 0; i < 4; i++) rchk(4'(i), 8'(8'h5A + i));
        rchk(4'h6, 8'h00);
        rchk(4'hF, 8'h00);
        run(3'h3);
        rchk(4'h1, 8'h5C);
        chk(cmpOut, 2'b10);
        $display("test registers done");
    endtask : t_regs

    task automatic t_alu;
        logic [7:0] b, r;
        for (int f = 0; f < 8; f++) begin
            b = (f == 7) ? 8'hF0 : 8'h0F;
            r = alu(f, 8'hF0, b);
            wr(4'h8, 16'h0040 | 16'(f));
            wr(4'h0, 16'h00F0);
            wr(4'h2, {8'h00, b});
            run(3'h0);
            chk(cmpOut[0], r == b);
            chk(zeroOut[0], r == 8'h00);
            chk(onesOut[0], r == 8'hFF);
            rchk(4'h0, r);
        end
        $display("test alu done");
    endtask : t_alu

    // Hold a no-write add or subtract word and watch its flags
    task automatic oc(input logic [2:0] s, input logic [7:0] a, b,
                      input logic o, c);
        wr(4'h0, {8'h00, a});
        wr(4'h2, {8'h00, b});
        @(posedge ref_clk);
        cfgAddr <= s;
        repeat (3) @(posedge ref_clk);
        #1;
        chk(ovfOut, o);
        chk(chainCarryOut, c);
        @(posedge ref_clk);
        cfgAddr <= 3'h7;
    endtask : oc

    task automatic t_flags;
        oc(3'h4, 8'h7F, 8'h01, 1'b1, 1'b0);
        oc(3'h4, 8'hFF, 8'h01, 1'b0, 1'b1);
        oc(3'h5, 8'h00, 8'h01, 1'b0, 1'b1);
        oc(3'h5, 8'h80, 8'h01, 1'b1, 1'b0);
        wr(4'h0, 16'h0010);
        wr(4'h2, 16'h0020);
        chainCarryIn <= 1'b1;
        run(3'h6);
        chainCarryIn <= 1'b0;
        rchk(4'h0, 8'h31);
        wr(4'h0, 16'h0000);
        chainZeroIn <= 1'b1;
        repeat (3) @(posedge ref_clk);
        chk(chainZeroOut, 1'b1);
        chainZeroIn <= 1'b0;
        repeat (3) @(posedge ref_clk);
        chk(chainZeroOut, 1'b0);
        $display("test flags done");
    endtask : t_flags

    task automatic t_queue;
        for (int i = 1; i < 6; i++) wr(4'h4, 16'(8'h11 * i));
        @(posedge ref_clk);
        chk(qFull, 2'b01);
        rchk(4'h4, 8'h00);
        for (int i = 1; i < 6; i++) begin
            run(3'h1);
            rchk(4'h0, (i < 5) ? 8'(8'h11 * i) : 8'h44);
        end
        chk(qEmpty, 2'b11);
        for (int i = 0; i < 5; i++) begin
            wr(4'h0, 16'(8'hA0 + i));
            run(3'h2);
        end
        chk(qFull, 2'b10);
        for (int i = 0; i < 5; i++) rchk(4'h5, (i < 4) ? 8'(8'hA0 + i) : 8'h00);
        chk(qEmpty, 2'b11);
        $display("test queue done");
    endtask : t_queue

    task automatic t_sop;
        logic [3:0] i;
        for (int n = 0; n < 16; n++) begin
            i = 4'(n);
            @(posedge ref_clk);
            sopIn <= {9'h1FF, i[3], 2'b11, i[1], 5'h1F, i[2], 4'hF, i[0]};
            #1;
            chk(sopOut[0], (i[0] & ~i[1]) | i[2]);
            chk(sopOut[7], i[3]);
            @(posedge ref_clk);
            #1;
            chk(sopOut[1], i[0] & ~i[1]);
        end
        $display("test arrays done");
    endtask : t_sop

    // Array setup: out0 = term0 | term7, out1 = term0 flopped
    initial begin
        reset = 1'b1;
        {chainCarryIn, chainZeroIn, cfgAddr, sopIn} = {2'b00, 3'h7, 24'h0};
        {trueSel, compSel, orSel, regSel} = '0;
        {trueSel[0], compSel[11], trueSel[89], trueSel[134]} = 4'hF;
        {orSel[0], orSel[7], orSel[8], orSel[59], regSel[1]} = 5'h1F;
        qDirOut = 2'b10;
        repeat (20) @(posedge ref_clk);
        reset <= 1'b0;
        t_reset();
        t_regs();
        t_alu();
        t_flags();
        t_queue();
        t_sop();
        results();
    end
endmodule : tb_top
`default_nettype wire
